/* File: core/buck_consts.svh */
// Timing counts, thresholds and flag positions of the switcher sequencer.
// Assumes a 20 MHz control clock; all clock-cycle counts derive from it.
`ifndef BUCK_CONSTS_SVH
`define BUCK_CONSTS_SVH

// Clock rate
`define CLK_MHZ            20
// Least time in ns to clock cycles, rounded up
`define CYC_CEIL(ns)       ((((ns) * `CLK_MHZ) + 999) / 1000)

// Blanking after turn-on
`define T_TURN_ON_BLANK_NS 250
`define T_SC_BLANK_NS      200
`define TURN_ON_BLANK_CYC  `CYC_CEIL(`T_TURN_ON_BLANK_NS)
`define SC_BLANK_CYC       `CYC_CEIL(`T_SC_BLANK_NS)

// Minimum off time per soft-start stage
`define T_MINOFF_START_NS  62000
`define T_MINOFF_MID_NS    31000
`define T_MINOFF_NORM_NS   15500
`define MINOFF_START_CYC   `CYC_CEIL(`T_MINOFF_START_NS)
`define MINOFF_MID_CYC     `CYC_CEIL(`T_MINOFF_MID_NS)
`define MINOFF_NORM_CYC    `CYC_CEIL(`T_MINOFF_NORM_NS)

// Extra off time per light-load step
`define T_EXTRA_OFF_NS     2000
`define EXTRA_OFF_CYC      `CYC_CEIL(`T_EXTRA_OFF_NS)

// Soft start and open-loop blanking, in switching cycles
`define SS_STAGE_CYCLES    128
`define SS_CNT_LAST        7'h7f
`define SS_SHIFT           7
`define OLD_BLANK_CYCLES   7'h40

// Overload delay: 170 ms at 36 kHz as a switching-cycle count
`define OLP_DELAY_MS       170
`define OLP_REF_KHZ        36
`define OLP_CYCLES         (`OLP_DELAY_MS * `OLP_REF_KHZ)

// Peak-current level range
`define PEAK_LVL_MAX       2'h3
`define PEAK_LVL_MIN       2'h0

// Soft-start stages
`define SS_STAGE_ONE       2'h0
`define SS_STAGE_TWO       2'h1
`define SS_STAGE_NORM      2'h2

// Comparator flag positions
`define FLAG_COUNT         9
`define F_BIAS_UPPER       0
`define F_BIAS_LOWER       1
`define F_BIAS_RESTART     2
`define F_FB_SWITCH_ON     3
`define F_FB_OVERLOAD      4
`define F_FB_OPEN_LOOP     5
`define F_PEAK_LIMIT       6
`define F_SHORT_CIRCUIT    7
`define F_OVER_TEMP        8

`endif

/* File: core/buck_pkg.sv */
// Types shared by the switcher sequencer.
// Assumes buck_consts.svh supplies the numeric constants.
package buck_pkg;

  typedef enum logic [2:0] {
    ST_CHARGE = 3'b000,
    ST_OFF    = 3'b001,
    ST_ON     = 3'b010,
    ST_SHORT  = 3'b011,
    ST_FAULT  = 3'b100
  } ctl_state_t;

endpackage

/* File: core/tick_if.sv */
// Clear and elapsed-count link between sequencer and interval counter.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface tick_if #(
  parameter int W = 16
);
  logic         clr;
  logic [W-1:0] elapsed;

  modport ctl (output clr, input elapsed);
  modport cnt (input clr, output elapsed);
endinterface
`default_nettype wire

/* File: core/interval_counter.sv */
// Saturating oscillator-tick counter, cleared on request.
// Assumes clr is a single-cycle level from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module interval_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  // Tick link
  tick_if.cnt       tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  // Count ticks, hold at full scale
  always_comb begin
    s_d = s_q;
    if (tick.clr) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != {W{1'b1}}) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick.elapsed = s_q.cnt;

endmodule
`default_nettype wire

/* File: core/buck_switcher_control_fsm.sv */
// Start-up, switching and fault sequencer for a step-down power switcher.
// Assumes comparator flags arrive from analog and are asynchronous to the clock.
//
// How it works
// - Bias upper threshold starts, regulator off
// - Below lower threshold, regulator back on
// - Any fault stops gate switching
// - Fault discharges bias, waits restart threshold
// - Turn on when feedback low, min off done
// - Turn off at peak-current limit
// - Minimum off time ramps down in stages
// - Stages one and two each last 128 cycles
// - Light load lengthens off, lowers peak
// - Overload timer counts while feedback low
// - Overload fault after delay cycle count
// - Short circuit halts, resumes when removed
// - Over-temperature shuts down, then restarts
// - Open loop stops and restarts
// - Open loop ignored first 64 cycles
// - Blanking after turn-on, shorter for short
`include "buck_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module buck_switcher_control_fsm
  import buck_pkg::*;
#(
  parameter int TW         = 16,
  parameter int OLP_W      = 13,
  parameter int OLP_CYCLES = `OLP_CYCLES
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // Bias supply comparators
  input  wire logic       i_bias_above_upper,
  input  wire logic       i_bias_below_lower,
  input  wire logic       i_bias_below_restart,
  // Feedback comparators
  input  wire logic       i_fb_below_switch_on,
  input  wire logic       i_fb_below_overload,
  input  wire logic       i_fb_below_open_loop,
  // Current and thermal comparators
  input  wire logic       i_peak_limit_hit,
  input  wire logic       i_short_circuit,
  input  wire logic       i_over_temp,
  // Power stage controls
  output logic            o_gate_on,
  output logic            o_hv_reg_en,
  output logic            o_bias_discharge_en,
  output logic [1:0]      o_peak_level,
  // Status
  output logic [1:0]      o_soft_stage,
  output logic            o_short_hold
);

  typedef struct packed {
    ctl_state_t             st;
    logic [`FLAG_COUNT-1:0] sync1;
    logic [`FLAG_COUNT-1:0] sync2;
    logic [1:0]             stage;
    logic [6:0]             ss_cnt;
    logic [6:0]             old_cnt;
    logic [OLP_W-1:0]       olp_cnt;
    logic [1:0]             peak;
    logic                   gate;
    logic                   hv_en;
    logic                   dis;
    logic                   sc;
  } ctl_t;

  localparam logic [TW-1:0]    LEB_C = TW'(`TURN_ON_BLANK_CYC);
  localparam logic [TW-1:0]    SCB_C = TW'(`SC_BLANK_CYC);
  localparam logic [OLP_W-1:0] OLP_C = OLP_W'(OLP_CYCLES);

  ctl_t          s_q;
  ctl_t          s_d;
  logic [TW-1:0] minoff;
  logic [TW-1:0] elapsed;
  logic          tick_clr;
  logic          ol_armed;
  logic [`FLAG_COUNT-1:0] flags;

  tick_if #(.W(TW)) tick ();

  interval_counter #(.W(TW)) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .tick      (tick.cnt)
  );

  assign tick.clr = tick_clr;
  assign elapsed  = tick.elapsed;

  // Stage-dependent minimum off time, linear ramp across the stage
  function automatic logic [TW-1:0] minoff_of(input logic [1:0] stage,
                                              input logic [6:0] cnt,
                                              input logic [1:0] peak);
    logic [TW-1:0] hi;
    logic [TW-1:0] lo;
    logic [31:0]   red;
    logic [TW-1:0] ext;
    hi = TW'(`MINOFF_NORM_CYC);
    lo = TW'(`MINOFF_NORM_CYC);
    unique case (stage)
      `SS_STAGE_ONE: begin
        hi = TW'(`MINOFF_START_CYC);
        lo = TW'(`MINOFF_MID_CYC);
      end
      `SS_STAGE_TWO: begin
        hi = TW'(`MINOFF_MID_CYC);
        lo = TW'(`MINOFF_NORM_CYC);
      end
      default: begin
        hi = TW'(`MINOFF_NORM_CYC);
        lo = TW'(`MINOFF_NORM_CYC);
      end
    endcase
    red = (32'(hi - lo) * 32'(cnt)) >> `SS_SHIFT;
    ext = TW'(32'(`PEAK_LVL_MAX - peak) * 32'(`EXTRA_OFF_CYC));
    return TW'(hi - TW'(red) + ext);
  endfunction

  assign flags = {i_over_temp, i_short_circuit, i_peak_limit_hit,
                  i_fb_below_open_loop, i_fb_below_overload, i_fb_below_switch_on,
                  i_bias_below_restart, i_bias_below_lower, i_bias_above_upper};

  assign minoff   = minoff_of(s_q.stage, s_q.ss_cnt, s_q.peak);
  assign ol_armed = (s_q.old_cnt >= `OLD_BLANK_CYCLES);

  always_comb begin
    s_d       = s_q;
    s_d.sync1 = flags;
    s_d.sync2 = s_q.sync1;

    // Bias hysteresis while running
    if (s_q.st != ST_CHARGE && s_q.st != ST_FAULT) begin
      if (s_q.sync2[`F_BIAS_LOWER]) begin
        s_d.hv_en = 1'b1;
      end else if (s_q.sync2[`F_BIAS_UPPER]) begin
        s_d.hv_en = 1'b0;
      end
    end

    unique case (s_q.st)
      ST_CHARGE: begin
        s_d.hv_en = 1'b1;
        s_d.dis   = 1'b0;
        if (s_q.sync2[`F_BIAS_UPPER]) begin
          s_d.st      = ST_OFF;
          s_d.hv_en   = 1'b0;
          s_d.stage   = `SS_STAGE_ONE;
          s_d.ss_cnt  = '0;
          s_d.old_cnt = '0;
          s_d.olp_cnt = '0;
          s_d.peak    = `PEAK_LVL_MAX;
        end
      end
      ST_OFF: begin
        if (elapsed >= minoff && s_q.sync2[`F_FB_SWITCH_ON]) begin
          s_d.st   = ST_ON;
          s_d.gate = 1'b1;
          // Soft-start stage progress
          if (s_q.stage != `SS_STAGE_NORM) begin
            if (s_q.ss_cnt == `SS_CNT_LAST) begin
              s_d.stage  = s_q.stage + 2'h1;
              s_d.ss_cnt = '0;
            end else begin
              s_d.ss_cnt = s_q.ss_cnt + 7'h1;
            end
          end
          if (!ol_armed) begin
            s_d.old_cnt = s_q.old_cnt + 7'h1;
          end
          // Overload counted in switching cycles
          if (s_q.sync2[`F_FB_OVERLOAD]) begin
            if (s_q.olp_cnt != {OLP_W{1'b1}}) begin
              s_d.olp_cnt = s_q.olp_cnt + 1'b1;
            end
          end else begin
            s_d.olp_cnt = '0;
          end
          // Load estimate from how long the off phase ran
          if (elapsed > TW'(32'(minoff) * 2)) begin
            if (s_q.peak != `PEAK_LVL_MIN) begin
              s_d.peak = s_q.peak - 2'h1;
            end
          end else if (elapsed == minoff && s_q.peak != `PEAK_LVL_MAX) begin
            s_d.peak = s_q.peak + 2'h1;
          end
        end
      end
      ST_ON: begin
        if (elapsed >= SCB_C && s_q.sync2[`F_SHORT_CIRCUIT]) begin
          s_d.st   = ST_SHORT;
          s_d.gate = 1'b0;
          s_d.sc   = 1'b1;
        end else if (elapsed >= LEB_C && s_q.sync2[`F_PEAK_LIMIT]) begin
          s_d.st   = ST_OFF;
          s_d.gate = 1'b0;
        end
      end
      ST_SHORT: begin
        if (!s_q.sync2[`F_SHORT_CIRCUIT]) begin
          s_d.st = ST_OFF;
          s_d.sc = 1'b0;
        end
      end
      ST_FAULT: begin
        s_d.gate  = 1'b0;
        s_d.dis   = 1'b1;
        s_d.hv_en = 1'b0;
        if (s_q.sync2[`F_BIAS_RESTART]) begin
          s_d.st    = ST_CHARGE;
          s_d.dis   = 1'b0;
          s_d.hv_en = 1'b1;
        end
      end
      default: begin
        s_d.st = ST_FAULT;
      end
    endcase

    // Latching faults override the running states
    if (s_q.st == ST_OFF || s_q.st == ST_ON || s_q.st == ST_SHORT) begin
      if (s_q.sync2[`F_OVER_TEMP]
          || (ol_armed && s_q.sync2[`F_FB_OPEN_LOOP])
          || s_q.olp_cnt >= OLP_C) begin
        s_d.st    = ST_FAULT;
        s_d.gate  = 1'b0;
        s_d.dis   = 1'b1;
        s_d.hv_en = 1'b0;
        s_d.sc    = 1'b0;
      end
    end

    tick_clr = (s_d.st != s_q.st);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q       <= '0;
      s_q.st    <= ST_CHARGE;
      s_q.hv_en <= 1'b1;
      s_q.peak  <= `PEAK_LVL_MAX;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_gate_on           = s_q.gate;
  assign o_hv_reg_en         = s_q.hv_en;
  assign o_bias_discharge_en = s_q.dis;
  assign o_peak_level        = s_q.peak;
  assign o_soft_stage        = s_q.stage;
  assign o_short_hold        = s_q.sc;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_charge_start: assert property (
    s_q.st == ST_CHARGE && s_q.sync2[`F_BIAS_UPPER] |=> s_q.st == ST_OFF && !o_hv_reg_en)
    else $error("Start-up at upper bias threshold missed");
  a_hv_cause: assert property (
    $rose(o_hv_reg_en) |-> $past(s_q.sync2[`F_BIAS_LOWER]) || $past(s_q.sync2[`F_BIAS_RESTART]))
    else $error("Regulator enabled without a low bias flag");
  a_fault_outputs: assert property (
    s_q.st == ST_FAULT |-> !o_gate_on && o_bias_discharge_en && !o_hv_reg_en)
    else $error("Fault state drives wrong outputs");
  a_restart_wait: assert property (
    s_q.st == ST_FAULT && !s_q.sync2[`F_BIAS_RESTART] |=> s_q.st == ST_FAULT && !o_hv_reg_en)
    else $error("Left fault before restart threshold");
  a_turn_on_cause: assert property (
    $rose(o_gate_on) |-> $past(s_q.sync2[`F_FB_SWITCH_ON]) && $past(elapsed) >= $past(minoff))
    else $error("Gate on without feedback low and off time done");
  a_limit_off: assert property (
    s_q.st == ST_ON && elapsed >= LEB_C && s_q.sync2[`F_PEAK_LIMIT] |=> !o_gate_on)
    else $error("Gate stayed on at peak limit");
  a_stage_step: assert property (
    $changed(s_q.stage) && $past(s_q.st) != ST_CHARGE |-> $past(s_q.ss_cnt) == `SS_CNT_LAST)
    else $error("Soft-start stage moved early");
  a_blank_hold: assert property (
    s_q.st == ST_ON && elapsed < SCB_C && !s_q.sync2[`F_OVER_TEMP]
      && !(ol_armed && s_q.sync2[`F_FB_OPEN_LOOP]) && s_q.olp_cnt < OLP_C
      |=> o_gate_on)
    else $error("Gate turned off inside blanking");
  a_olp_trip: assert property (
    (s_q.st == ST_OFF || s_q.st == ST_ON) && s_q.olp_cnt >= OLP_C |=> s_q.st == ST_FAULT)
    else $error("Overload delay passed without fault");
  a_short_resume: assert property (
    s_q.st == ST_SHORT && !s_q.sync2[`F_SHORT_CIRCUIT] && !s_q.sync2[`F_OVER_TEMP]
      && !(ol_armed && s_q.sync2[`F_FB_OPEN_LOOP]) && s_q.olp_cnt < OLP_C
      |=> s_q.st == ST_OFF && !o_short_hold)
    else $error("No resume after short removed");
  a_open_loop_blank: assert property (
    s_q.st == ST_OFF && !ol_armed && !s_q.sync2[`F_OVER_TEMP] && s_q.olp_cnt < OLP_C
      |=> s_q.st != ST_FAULT)
    else $error("Open loop acted during blanking");

  c_reach_norm: cover property (s_q.stage == `SS_STAGE_NORM && $rose(o_gate_on));
  c_short_cycle: cover property (s_q.st == ST_SHORT ##1 s_q.st == ST_OFF);
  c_fault_restart: cover property (s_q.st == ST_FAULT ##1 s_q.st == ST_CHARGE);
  c_light_load: cover property (o_peak_level == `PEAK_LVL_MIN && o_gate_on);

endmodule
`default_nettype wire

/* File: testbench/buck_plant_model.sv */
// Behavioural power stage: bias capacitor, inductor current, feedback.
// Assumes gate, regulator and discharge controls from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module buck_plant_model (
  // Clock
  input  wire logic        i_ref_clk,
  // Controls from sequencer
  input  wire logic        i_gate_on,
  input  wire logic        i_hv_reg_en,
  input  wire logic        i_bias_discharge_en,
  // Load: off cycles until feedback falls
  input  wire logic [11:0] i_fb_delay,
  // Comparator flags
  output logic             o_bias_above_upper,
  output logic             o_bias_below_lower,
  output logic             o_bias_below_restart,
  output logic             o_fb_below_switch_on,
  output logic             o_peak_limit_hit,
  // Bias level, tenths of a volt times ten
  output int               o_bias_level
);
  int bias_lvl = 0;
  int on_cnt   = 0;
  int off_cnt  = 0;
  int tick     = 0;

  // Flags change just after the falling edge
  always @(negedge i_ref_clk) begin
    tick = tick + 1;
    if (i_bias_discharge_en)
      bias_lvl = bias_lvl - 1;
    else if (i_hv_reg_en)
      bias_lvl = bias_lvl + 1;
    else if (tick % 8 == 0)
      bias_lvl = bias_lvl - 1;
    if (bias_lvl < 0)
      bias_lvl = 0;
    on_cnt  = i_gate_on ? on_cnt + 1 : 0;
    off_cnt = i_gate_on ? 0 : off_cnt + 1;
    o_bias_above_upper   <= (bias_lvl >= 850);
    o_bias_below_lower   <= (bias_lvl < 820);
    o_bias_below_restart <= (bias_lvl < 450);
    o_fb_below_switch_on <= (off_cnt >= int'(i_fb_delay));
    o_peak_limit_hit     <= (on_cnt >= 2);
    o_bias_level         <= bias_lvl;
  end
endmodule
`default_nettype wire

/* File: testbench/test_buck_switcher_control_fsm.sv */
// Self-checking bench of the switcher sequencer with a power stage model.
// Assumes the sequencer with a short overload count of 8 switching cycles.
`timescale 1ns/100ps
`default_nettype none
module test_buck_switcher_control_fsm;
  import buck_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        up, lo, rs, fbs, pk_hit;
  logic        ovl = 1'b0, opl = 1'b0, sc = 1'b0, ot = 1'b0;
  logic [11:0] fb_dly = 12'h014;
  logic        gate, hv, dis, hold;
  logic [1:0]  peak, stage;
  int          bias, mismatches, check_count, cyc, ons, on_len, off_len, n, hv_ups;
  logic        g_q, hv_q;
  logic [1:0]  pk_s, st_s;
  logic [15:0] seed = 16'hf8b9;

  always #25 clk = ~clk;

  buck_switcher_control_fsm #(.OLP_CYCLES(8)) dut (
    .i_ref_clk(clk), .i_reset(rst), .i_bias_above_upper(up),
    .i_bias_below_lower(lo), .i_bias_below_restart(rs), .i_fb_below_switch_on(fbs),
    .i_fb_below_overload(ovl), .i_fb_below_open_loop(opl), .i_peak_limit_hit(pk_hit),
    .i_short_circuit(sc), .i_over_temp(ot), .o_gate_on(gate), .o_hv_reg_en(hv),
    .o_bias_discharge_en(dis), .o_peak_level(peak), .o_soft_stage(stage),
    .o_short_hold(hold));

  buck_plant_model plant (
    .i_ref_clk(clk), .i_gate_on(gate), .i_hv_reg_en(hv), .i_bias_discharge_en(dis),
    .i_fb_delay(fb_dly), .o_bias_above_upper(up), .o_bias_below_lower(lo),
    .o_bias_below_restart(rs), .o_fb_below_switch_on(fbs), .o_peak_limit_hit(pk_hit),
    .o_bias_level(bias));

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction

  // Least off time in stage one at a peak level
  function automatic int exp_minoff(int cnt, logic [1:0] lvl);
    return 1240 - ((620 * cnt) >> 7) + (3 - int'(lvl)) * 40;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int got, input int lo_b, input int hi_b);
    check_count++;
    if (got < lo_b || got > hi_b) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo_b, hi_b);
    end
  endtask

  function automatic logic sig(int w);
    case (w)
      0: return gate;
      1: return hv;
      2: return dis;
      default: return hold;
    endcase
  endfunction

  task automatic wait_sig(input int w, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sig(w) !== v; i++) @(negedge clk);
    chk(16'(sig(w)), 16'(v));
  endtask

  task automatic turn_on(input int lim);
    wait_sig(0, 1'b0, 50);
    wait_sig(0, 1'b1, lim);
  endtask

  task automatic restart();
    wait_sig(1, 1'b1, 2000);
    chk_range(bias, 440, 449);
    chk(16'(dis), 16'h0000);
    wait_sig(1, 1'b0, 2000);
    chk(16'(stage), 16'h0000);
    chk(16'(peak), 16'h0003);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watch every switching period and fault span, away from the launching edge
  always @(negedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      give_verdict();
    end
    if (!rst) begin
      if (gate) begin
        if (!g_q) begin
          if (st_s == 2'h0) chk_range(off_len, exp_minoff(n, pk_s), 99999);
          n++;
          ons++;
          on_len = 0;
        end
        on_len++;
      end else begin
        if (g_q && !hold && !dis) chk_range(on_len, 5, 10);
        off_len = g_q ? 1 : off_len + 1;
        pk_s = peak;
        st_s = stage;
      end
      if (hv && !hv_q && !dis && n > 0) begin
        chk_range(bias, 815, 819);
        hv_ups++;
      end
      if (dis) begin
        chk(16'(gate), 16'h0000);
        chk(16'(hv), 16'h0000);
        n = 0;
      end
    end
    g_q  = gate;
    hv_q = hv;
  end

  initial begin
    int o0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(16'({gate, hv, dis, hold}), 16'h0004);
    chk(16'({peak, stage}), 16'h000c);
    rst = 1'b0;
    wait_sig(1, 1'b0, 2000);
    chk_range(bias, 850, 854);
    repeat (6) begin
      fb_dly = 12'h001 + 12'(xs() % 64);
      turn_on(2000);
    end
    chk_range(hv_ups, 1, 1000);
    fb_dly = 12'hbb8;
    turn_on(5000);
    @(negedge clk);
    chk(16'(peak), 16'h0002);
    fb_dly = 12'h001 + 12'(xs() % 16);
    turn_on(2000);
    @(negedge clk);
    chk(16'(peak), 16'h0003);
    turn_on(2000);
    sc = 1'b1;
    wait_sig(3, 1'b1, 12);
    chk(16'({gate, dis}), 16'h0000);
    repeat (10) @(negedge clk);
    chk(16'({gate, hold}), 16'h0001);
    sc = 1'b0;
    wait_sig(3, 1'b0, 8);
    chk(16'(dis), 16'h0000);
    turn_on(2000);
    ot = 1'b1;
    wait_sig(2, 1'b1, 10);
    chk(16'(gate), 16'h0000);
    ot = 1'b0;
    restart();
    o0  = ons;
    ovl = 1'b1;
    opl = 1'b1;
    repeat (3) turn_on(2000);
    chk(16'(dis), 16'h0000);
    opl = 1'b0;
    wait_sig(2, 1'b1, 12000);
    chk_range(ons - o0, 8, 9);
    ovl = 1'b0;
    restart();
    give_verdict();
  end
endmodule
`default_nettype wire
